// [dcrb_pkg.sv]
// constants for the converter setup register bank
`default_nettype none
package dcrb_pkg;
    // ====================================================
    // register indices (byte address = index * 4)
    localparam logic [2:0]  IDX_NOP      = 3'h0;
    localparam logic [2:0]  IDX_CODE     = 3'h1;
    localparam logic [2:0]  IDX_SETUP    = 3'h2;
    localparam logic [2:0]  IDX_ISTAT    = 3'h3;
    localparam logic [2:0]  IDX_ICLR     = 3'h4;
    localparam logic [2:0]  IDX_IEN      = 3'h5;
    // ====================================================
    // reset values and setup write mask
    localparam logic [15:0] CODE_RST     = 16'h0000;
    localparam logic [15:0] SETUP_RST    = 16'h0036;
    localparam logic [15:0] SETUP_WMASK  = 16'h7BFF;
    localparam logic [1:0]  IEN_RST      = 2'h0;
    // ====================================================
    // setup word field positions
    localparam int          THR_LSB      = 13;
    localparam int          CLK_DIV_BIT  = 12;
    localparam int          CLK_EN_BIT   = 11;
    localparam int          UBM_IRQ_BIT  = 9;
    localparam int          IRQ_PIN_BIT  = 8;
    localparam int          CLR_PIN_BIT  = 7;
    localparam int          PORT_OFF_BIT = 6;
    localparam int          RATE_BIT     = 5;
    localparam int          CHK_BIT      = 4;
    localparam int          POL_BIT      = 3;
    localparam int          TRIG_BIT     = 2;
    localparam int          HOLD_BIT     = 1;
    localparam int          EARLY_BIT    = 0;
    // ====================================================
    // interrupt status bits
    localparam int          EV_CRC       = 0;
    localparam int          EV_CLR       = 1;
    localparam int          EV_N         = 2;
    // ====================================================
    // clock output divider: 128 = two halves of 64 edges
    localparam int          CLK_DIVIDE   = 128;
    localparam logic [5:0]  HALF_LAST    = 6'(CLK_DIVIDE / 2 - 1);
    localparam logic [3:0]  BAD_MAX      = 4'h8;
endpackage
`default_nettype wire

// [dcrb_top.sv]
// converter setup register bank with wishbone slave
// Function
// - no-op register ignores writes, reads zero
// - 16-bit output code register, reset zero
// - setup word resets 0036h, bits 15,10 read-only
// - bad-frame run threshold 1,2,4,8 sets status
// - clock output undivided or divided by 128
// - clock output driven only when enabled
// - break-mode interrupt on serial transmit when enabled
// - interrupt pin works only when enabled
// - data-in pin transitions request clear state in break mode when enabled
// - serial port off bit, reset zero
// - rate select 1200 or 9600 break mode
// - frame check enabled by default, host appends check
// - interrupt pin active low or high
// - interrupt pin edge pulse or level
// - data-out tristate hold, else drive during select
// - data-out launched on rising or falling edge
//
// Added by the designer: the Wishbone slave port.
`default_nettype none
module dcrb_top (
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [4:2]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        OSC_IN,
    input  wire logic        FRAME_DONE,
    input  wire logic        FRAME_BAD,
    input  wire logic        SCLK,
    input  wire logic        CS_N,
    input  wire logic        SDO_DATA,
    input  wire logic        SDI,
    output logic      [15:0] DAC_CODE,
    output logic             CLK_OUT,
    output logic             CLK_OUT_OE,
    output logic             IRQ_PIN,
    output logic             SERIAL_TX_IRQ,
    output logic             DAC_CLEAR,
    output logic             SERIAL_PORT_OFF,
    output logic             BREAK_MODE,
    output logic             FRAME_CHECK_EN,
    output logic             SDO_O,
    output logic             SDO_OE,
    output logic             INT
);

    // ====================================================
    // helpers
    function automatic logic [15:0] lane_mask(
        input logic [3:0] sel
    );
        lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction

    function automatic logic [3:0] run_limit(
        input logic [1:0] code
    );
        run_limit = 4'h1 << code;
    endfunction

    function automatic logic idx_hit(
        input logic [2:0] adr,
        input logic [2:0] idx
    );
        idx_hit = (adr == idx);
    endfunction

    // ====================================================
    // bus decode
    logic        req;
    logic        wr;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic        ack_r;

    assign req   = CYC_I & STB_I & ~ack_r;
    assign wr    = req & WE_I;
    assign wmask = lane_mask(SEL_I);
    assign wdata = DAT_I[15:0];

    // ====================================================
    // registers
    logic [15:0]             code_r;
    logic [15:0]             setup_r;
    logic [dcrb_pkg::EV_N-1:0] istat_r;
    logic [dcrb_pkg::EV_N-1:0] ien_r;
    logic [dcrb_pkg::EV_N-1:0] ev;
    logic [dcrb_pkg::EV_N-1:0] iclr;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            code_r <= dcrb_pkg::CODE_RST;
        end else if (wr && idx_hit(ADR_I, dcrb_pkg::IDX_CODE)) begin
            code_r <= (code_r & ~wmask) | (wdata & wmask);
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            setup_r <= dcrb_pkg::SETUP_RST;
        end else if (wr && idx_hit(ADR_I, dcrb_pkg::IDX_SETUP)) begin
            setup_r <= (setup_r & ~(wmask & dcrb_pkg::SETUP_WMASK))
                     | (wdata & wmask & dcrb_pkg::SETUP_WMASK);
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ien_r <= dcrb_pkg::IEN_RST;
        end else if (wr && idx_hit(ADR_I, dcrb_pkg::IDX_IEN) && SEL_I[0]) begin
            ien_r <= wdata[dcrb_pkg::EV_N-1:0];
        end
    end

    assign iclr = (wr && idx_hit(ADR_I, dcrb_pkg::IDX_ICLR) && SEL_I[0])
                ? wdata[dcrb_pkg::EV_N-1:0] : '0;

    // set wins over clear
    always_ff @(posedge CLK) begin
        if (SRST) begin
            istat_r <= '0;
        end else begin
            istat_r <= (istat_r & ~iclr) | ev;
        end
    end

    // ====================================================
    // setup fields
    logic [1:0] thr_code;
    logic       div_sel;
    logic       clk_en;
    logic       uart_break_irq_enable;
    logic       irq_pin_en;
    logic       clear_pin_enable;
    logic       port_off;
    logic       rate_fast;
    logic       chk_en;
    logic       pol_high;
    logic       trig_level;
    logic       sdo_hold;
    logic       early;
    logic       brk;

    assign thr_code   = setup_r[dcrb_pkg::THR_LSB +: 2];
    assign div_sel    = setup_r[dcrb_pkg::CLK_DIV_BIT];
    assign clk_en     = setup_r[dcrb_pkg::CLK_EN_BIT];
    assign uart_break_irq_enable = setup_r[dcrb_pkg::UBM_IRQ_BIT];
    assign irq_pin_en = setup_r[dcrb_pkg::IRQ_PIN_BIT];
    assign clear_pin_enable = setup_r[dcrb_pkg::CLR_PIN_BIT];
    assign port_off   = setup_r[dcrb_pkg::PORT_OFF_BIT];
    assign rate_fast  = setup_r[dcrb_pkg::RATE_BIT];
    assign chk_en     = setup_r[dcrb_pkg::CHK_BIT];
    assign pol_high   = setup_r[dcrb_pkg::POL_BIT];
    assign trig_level = setup_r[dcrb_pkg::TRIG_BIT];
    assign sdo_hold   = setup_r[dcrb_pkg::HOLD_BIT];
    assign early      = setup_r[dcrb_pkg::EARLY_BIT];
    assign brk        = rate_fast & ~port_off;

    // ====================================================
    // bus answer
    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h0000_0000;
        if (ADR_I == dcrb_pkg::IDX_NOP) begin
            rdata = 32'h0000_0000;
        end else if (ADR_I == dcrb_pkg::IDX_CODE) begin
            rdata[15:0] = code_r;
        end else if (ADR_I == dcrb_pkg::IDX_SETUP) begin
            rdata[15:0] = setup_r & dcrb_pkg::SETUP_WMASK;
        end else if (ADR_I == dcrb_pkg::IDX_ISTAT) begin
            rdata[dcrb_pkg::EV_N-1:0] = istat_r;
        end else if (ADR_I == dcrb_pkg::IDX_ICLR) begin
            rdata = 32'h0000_0000;
        end else if (ADR_I == dcrb_pkg::IDX_IEN) begin
            rdata[dcrb_pkg::EV_N-1:0] = ien_r;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            DAT_O <= 32'h0000_0000;
        end else if (req && !WE_I) begin
            DAT_O <= rdata;
        end
    end

    assign ACK_O = ack_r;

    // ====================================================
    // bad-frame run counter
    logic [3:0] bad_r;
    logic [3:0] bad_nxt;

    assign bad_nxt = (bad_r == dcrb_pkg::BAD_MAX) ? bad_r : bad_r + 4'h1;

    always_ff @(posedge CLK) begin
        if (SRST || !chk_en) begin
            bad_r <= 4'h0;
        end else if (FRAME_DONE) begin
            bad_r <= FRAME_BAD ? bad_nxt : 4'h0;
        end
    end

    assign ev[dcrb_pkg::EV_CRC] = chk_en & FRAME_DONE & FRAME_BAD
                                & (bad_nxt == run_limit(thr_code));

    // ====================================================
    // clear pin
    logic sdi_p;
    logic clr_ev;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            sdi_p <= 1'b0;
        end else begin
            sdi_p <= SDI;
        end
    end

    assign clr_ev = clear_pin_enable & brk & (SDI ^ sdi_p);
    assign ev[dcrb_pkg::EV_CLR] = clr_ev;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            DAC_CLEAR <= 1'b0;
        end else begin
            DAC_CLEAR <= clr_ev;
        end
    end

    // ====================================================
    // clock output
    logic       osc_p;
    logic [5:0] half_r;
    logic       slow_r;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            osc_p <= 1'b0;
        end else begin
            osc_p <= OSC_IN;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            half_r <= 6'h00;
            slow_r <= 1'b0;
        end else if (OSC_IN && !osc_p) begin
            half_r <= (half_r == dcrb_pkg::HALF_LAST) ? 6'h00 : half_r + 6'h01;
            if (half_r == dcrb_pkg::HALF_LAST) begin
                slow_r <= ~slow_r;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            CLK_OUT    <= 1'b0;
            CLK_OUT_OE <= 1'b0;
        end else begin
            CLK_OUT    <= clk_en & (div_sel ? slow_r : OSC_IN);
            CLK_OUT_OE <= clk_en;
        end
    end

    // ====================================================
    // interrupts
    logic irq;
    logic irq_p;
    logic pin_act;

    assign irq = |(istat_r & ien_r);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_p <= 1'b0;
        end else begin
            irq_p <= irq;
        end
    end

    assign pin_act = trig_level ? irq : (irq & ~irq_p);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            IRQ_PIN <= ~dcrb_pkg::SETUP_RST[dcrb_pkg::POL_BIT];
        end else begin
            IRQ_PIN <= (irq_pin_en & pin_act) ~^ pol_high;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            SERIAL_TX_IRQ <= 1'b0;
        end else begin
            SERIAL_TX_IRQ <= uart_break_irq_enable & brk & irq;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            INT <= 1'b0;
        end else begin
            INT <= irq;
        end
    end

    // ====================================================
    // code and serial port setup outputs
    always_ff @(posedge CLK) begin
        if (SRST) begin
            DAC_CODE        <= dcrb_pkg::CODE_RST;
            SERIAL_PORT_OFF <= 1'b0;
            BREAK_MODE      <= 1'b0;
            FRAME_CHECK_EN  <= 1'b0;
        end else begin
            DAC_CODE        <= code_r;
            SERIAL_PORT_OFF <= port_off;
            BREAK_MODE      <= brk;
            FRAME_CHECK_EN  <= chk_en;
        end
    end

    // ====================================================
    // data-out pin
    logic sclk_p;
    logic launch;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            sclk_p <= 1'b0;
        end else begin
            sclk_p <= SCLK;
        end
    end

    assign launch = early ? (sclk_p & ~SCLK) : (SCLK & ~sclk_p);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            SDO_O <= 1'b0;
        end else if (launch && !CS_N) begin
            SDO_O <= SDO_DATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            SDO_OE <= 1'b0;
        end else begin
            SDO_OE <= ~sdo_hold & ~CS_N;
        end
    end

endmodule
`default_nettype wire

// [dcrb_properties.sv]
// port assertions for the setup register bank
`default_nettype none
module dcrb_properties (
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [4:2]  ADR_I,
    input wire logic [3:0]  SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    input wire logic        CS_N,
    input wire logic [15:0] DAC_CODE,
    input wire logic        CLK_OUT,
    input wire logic        CLK_OUT_OE,
    input wire logic        IRQ_PIN,
    input wire logic        BREAK_MODE,
    input wire logic        SERIAL_PORT_OFF,
    input wire logic        SDO_OE,
    input wire logic        INT
);
    // ====
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    wire logic req = CYC_I && STB_I && !ACK_O;
    property p_ack_next; req |=> ACK_O; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_drop; ACK_O |=> !ACK_O; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack long");
    property p_nop_rd; req && !WE_I && ADR_I == 3'h0 |=> DAT_O == 32'h0; endproperty
    a_nop_rd: assert property (p_nop_rd) else $error("no-op read");
    property p_code;
        req && WE_I && ADR_I == 3'h1 && SEL_I[1:0] == 2'h3 |=> ##1
            DAC_CODE == $past(DAT_I[15:0], 2);
    endproperty
    a_code: assert property (p_code) else $error("code out");
    property p_setup_rd;
        req && !WE_I && ADR_I == 3'h2 |=> DAT_O[31:16] == 16'h0 && !DAT_O[15] && !DAT_O[10];
    endproperty
    a_setup_rd: assert property (p_setup_rd) else $error("reserved bits");
    property p_clk_off; !CLK_OUT_OE && !$past(CLK_OUT_OE) |-> !CLK_OUT; endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock out");
    property p_sdo_cs; SDO_OE |-> !$past(CS_N); endproperty
    a_sdo_cs: assert property (p_sdo_cs) else $error("sdo drive");
    property p_break; BREAK_MODE |-> !SERIAL_PORT_OFF; endproperty
    a_break: assert property (p_break) else $error("break mode");
    property p_rst; $fell(SRST) |-> !CLK_OUT_OE && DAC_CODE == 16'h0 && IRQ_PIN; endproperty
    a_rst: assert property (p_rst) else $error("reset outputs");
    c_wr: cover property (req && WE_I);
    c_int: cover property (INT);
    c_sdo: cover property (SDO_OE);
endmodule
bind dcrb_top dcrb_properties u_chk (.CLK(CLK), .SRST(SRST), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .CS_N(CS_N), .DAC_CODE(DAC_CODE), .CLK_OUT(CLK_OUT), .CLK_OUT_OE(CLK_OUT_OE),
    .IRQ_PIN(IRQ_PIN), .BREAK_MODE(BREAK_MODE), .SERIAL_PORT_OFF(SERIAL_PORT_OFF),
    .SDO_OE(SDO_OE), .INT(INT));
`default_nettype wire

// [dcrb_host_model.sv]
// serial host model: frames with or without check error
`default_nettype none
module dcrb_host_model (
    input  wire logic clk,
    output var logic  sclk,
    output var logic  cs_n,
    output var logic  sdo_data,
    output var logic  sdi,
    output var logic  fdone,
    output var logic  fbad
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    initial begin
        {sclk, sdo_data, sdi, fdone, fbad} = 5'h0;
        cs_n = 1'b1;
    end
    // clock stands still outside frames
    task automatic frame(input logic bad);
        int i;
        @(posedge clk);
        cs_n <= 1'b0;
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            sclk <= 1'b1;
            sdo_data <= i[0];
            @(posedge clk);
            sclk <= 1'b0;
        end
        @(posedge clk);
        fdone <= 1'b1;
        fbad <= bad;
        @(posedge clk);
        {fdone, fbad} <= 2'h0;
        cs_n <= 1'b1;
        sdo_data <= ~sdo_data;
    endtask
    task automatic flip_sdi;
        @(posedge clk);
        sdi <= ~sdi;
    endtask
endmodule
`default_nettype wire

// [dcrb_top_tb.sv]
// testbench for the setup register bank
`default_nettype none
module dcrb_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, osc = 0;
    logic [2:0] adr = 3'h0;
    logic [3:0] sel = 4'h0, wsel = 4'h3;
    logic [31:0] dati = 32'h0;
    wire logic [31:0] dato;
    wire logic ack, sclk, cs_n, sdod, sdi, fdone, fbad, clko, clkoe, irqp, txirq, clr;
    wire logic poff, brk, chken, sdoo, sdooe, intr;
    wire logic [15:0] code;
    logic [15:0] q;
    int mismatches = 0, compares = 0, i;
    logic [35:0] rows [12] = '{36'h2_0000_0036, 36'h1_0000_0000, 36'h0_0000_0000,
        36'h5_0000_0000, 36'h8_FFFF_0000, 36'h0_0000_0000, 36'h9_A5C3_0000,
        36'h1_0000_A5C3, 36'hA_FFFF_0000, 36'h2_0000_7BFF, 36'h6_0000_0000,
        36'h4_0000_0000};
    initial forever #50 clk = ~clk;
    always @(posedge clk) osc <= ~osc;
    dcrb_top DUT (.CLK(clk), .SRST(srst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dati), .DAT_O(dato), .ACK_O(ack), .OSC_IN(osc),
        .FRAME_DONE(fdone), .FRAME_BAD(fbad), .SCLK(sclk), .CS_N(cs_n), .SDO_DATA(sdod),
        .SDI(sdi), .DAC_CODE(code), .CLK_OUT(clko), .CLK_OUT_OE(clkoe), .IRQ_PIN(irqp),
        .SERIAL_TX_IRQ(txirq), .DAC_CLEAR(clr), .SERIAL_PORT_OFF(poff), .BREAK_MODE(brk),
        .FRAME_CHECK_EN(chken), .SDO_O(sdoo), .SDO_OE(sdooe), .INT(intr));
    dcrb_host_model hm (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdo_data(sdod), .sdi(sdi),
        .fdone(fdone), .fbad(fbad));
    task automatic summarize;
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [2:0] a, input logic [15:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, sel, dati} <= {1'b1, 1'b1, w, a, wsel, 16'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            mismatches++;
            summarize();
        end
        q = dato[15:0];
        {cyc, stb} <= 2'h0;
    endtask
    task automatic wint(input logic e);
        int n;
        n = 0;
        while (intr !== e && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk({15'h0, intr}, {15'h0, e});
        if (n >= 20) summarize();
    endtask
    task automatic sdo_run(input logic [15:0] cfg, input logic [15:0] oe, input logic [15:0] d);
        wb(1'b1, 3'h2, cfg);
        fork
            hm.frame(1'b0);
            begin
                repeat (3) @(negedge clk);
                chk({15'h0, sdooe}, oe);
                repeat (3) @(negedge clk);
                chk({15'h0, sdoo}, d);
            end
        join
    endtask
    task automatic clk_count(input logic [15:0] cfg, input int want);
        int n, t;
        logic p;
        wb(1'b1, 3'h2, cfg);
        repeat (4) @(negedge clk);
        chk({15'h0, clkoe}, {15'h0, cfg[11]});
        p = clko;
        t = 0;
        for (n = 0; n < 256; n++) begin
            @(negedge clk);
            if (clko !== p) t++;
            p = clko;
        end
        chk(t[15:0], want[15:0]);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 12; i++) begin
            wb(rows[i][35], rows[i][34:32], rows[i][31:16]);
            if (!rows[i][35]) chk(q, rows[i][15:0]);
        end
        @(negedge clk);
        chk(code, 16'hA5C3);
        chk({12'h0, chken, clkoe, poff, brk}, 16'hE);
        wsel = 4'h1;
        wb(1'b1, 3'h1, 16'h1234);
        wsel = 4'h3;
        wb(1'b0, 3'h1, 16'h0);
        chk(q, 16'hA534);
        wb(1'b1, 3'h2, 16'h213E);
        wb(1'b1, 3'h5, 16'h1);
        hm.frame(1'b1);
        hm.frame(1'b0);
        hm.frame(1'b1);
        repeat (4) @(negedge clk);
        chk({15'h0, intr}, 16'h0);
        hm.frame(1'b1);
        wint(1'b1);
        @(negedge clk);
        chk({15'h0, irqp}, 16'h1);
        chk({15'h0, txirq}, 16'h0);
        wb(1'b0, 3'h3, 16'h0);
        chk(q & 16'h1, 16'h1);
        wb(1'b1, 3'h4, 16'h1);
        wint(1'b0);
        sdo_run(16'h0034, 16'h1, 16'h1);
        sdo_run(16'h0035, 16'h1, 16'h0);
        sdo_run(16'h0036, 16'h0, 16'h1);
        hm.flip_sdi();
        repeat (2) @(negedge clk);
        chk({15'h0, clr}, 16'h0);
        wb(1'b1, 3'h5, 16'h2);
        wb(1'b1, 3'h2, 16'h02B4);
        hm.flip_sdi();
        repeat (2) @(negedge clk);
        chk({15'h0, clr}, 16'h1);
        @(negedge clk);
        chk({15'h0, txirq}, 16'h1);
        wb(1'b1, 3'h4, 16'h2);
        wint(1'b0);
        wb(1'b1, 3'h2, 16'h01B8);
        hm.flip_sdi();
        q = 16'h0;
        repeat (8) begin
            @(negedge clk);
            if (irqp === 1'b1) q++;
        end
        chk(q, 16'h1);
        clk_count(16'h1800, 256 / dcrb_pkg::CLK_DIVIDE);
        clk_count(16'h0800, 256);
        clk_count(16'h0036, 0);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(negedge clk);
        chk(code, 16'h0);
        chk({12'h0, chken, clkoe, poff, brk}, 16'h9);
        chk({15'h0, irqp}, 16'h1);
        wb(1'b0, 3'h2, 16'h0);
        chk(q, 16'h0036);
        wb(1'b0, 3'h3, 16'h0);
        chk(q, 16'h0);
        summarize();
    end
endmodule
`default_nettype wire
